// ---- temperature_alarm_logic.sv ----
// Alarm, status and power-mode logic of a two-channel temperature sensor.
// Assumes a framing engine on sys_clk delivers register strobes and the
// alert response arm pulse; the converter reports results on sys_clk.
//
// How it works
// RULE_01: Separate limits for local and remote channels.
// RULE_02: High or low limit breach sets status, alarm.
// RULE_03: Each alarm has a status bit, always readable.
// RULE_04: Status bits clear on read only when gone.
// RULE_05: Alarm pin held until status and response done.
// RULE_06: Config bit 7 masks the alarm pin; the code ignores it in second over-temperature mode.
// RULE_07: Host services alert via response address read.
// RULE_08: Pending device acks, returns address byte plus one.
// RULE_09: Non-pending device leaves acknowledge high.
// RULE_10: Lowest address wins; others retry later.
// RULE_11: Successful response releases pin, clears status.
// RULE_12: Over-temperature flags use limit and hysteresis.
// RULE_13: One hysteresis shared by both channels.
// RULE_14: Limits reset to 85, hysteresis 10, max 127.
// RULE_15: Host adds 64 offset in extended range.
// RULE_16: Second over-temperature mode reshapes alarm pin.
// RULE_17: Open diode sets status bit 2 and alarm.
// RULE_18: Host reads register 42h to release pin.
// RULE_19: Config bit 6 enters standby, no conversions.
// RULE_20: Standby drops conversion results in progress.
// RULE_21: Writing one-shot register starts one conversion.
// RULE_22: Comparisons continue against readings in standby.
// RULE_23: Status clears only after byte fully shifted.
`timescale 1ns/1ps
module temperature_alarm_logic (
	input wire logic sys_clk, // System clock, 40 MHz.
	input wire logic rst_n, // Asynchronous reset, active low.
	input wire logic ce, // Clock enable; low freezes state.
	input wire logic scl_pin, // Serial clock pin level.
	input wire logic sda_pin, // Serial data pin level.
	output logic sda_oe, // Pull serial data low.
	input wire logic wr_stb, // Register write strobe.
	input wire logic [7:0] wr_addr, // Register write address.
	input wire logic [7:0] wr_data, // Register write data.
	input wire logic rd_stb, // Register read strobe.
	input wire logic [7:0] rd_addr, // Register read address.
	output logic [7:0] rd_data, // Register read data.
	input wire logic status_read_done, // Status byte fully shifted.
	input wire logic ara_arm, // Alert response address seen.
	input wire logic conv_done, // Conversion result valid.
	input wire logic [7:0] local_reading, // Local result.
	input wire logic [7:0] remote_reading, // Remote result.
	input wire logic diode_open, // Remote diode open, async.
	output logic conv_enable, // Continuous conversions allowed.
	output logic conv_start, // Start a single conversion.
	output logic alert_oe, // Pull alarm pin low.
	output logic overtemp_oe // Pull overtemp_out_n low.
);
	typedef struct packed {
		logic [1:0] open_s;
		logic [7:0] local_temp;
		logic [7:0] remote_temp;
		logic [7:0] local_high;
		logic [7:0] local_low;
		logic [7:0] remote_high;
		logic [7:0] remote_low;
		logic [7:0] local_ot;
		logic [7:0] remote_ot;
		logic [7:0] hyst;
		logic [7:0] cfg;
		logic [7:0] status;
		logic [7:0] status_seen;
		logic pending;
		logic one_shot_pend;
		logic conv_start;
		logic conv_enable;
		logic alert_oe;
		logic overtemp_oe;
		logic [7:0] rd_data;
	} top_reg_t;

	localparam top_reg_t TOP_RST = '{open_s: 2'b00,
		local_temp: 8'h00, remote_temp: 8'h00,
		local_high: temp_alarm_pkg::HIGH_LIMIT_RST,
		local_low: temp_alarm_pkg::LOW_LIMIT_RST,
		remote_high: temp_alarm_pkg::HIGH_LIMIT_RST,
		remote_low: temp_alarm_pkg::LOW_LIMIT_RST,
		local_ot: temp_alarm_pkg::OT_LIMIT_RST, // RULE_14
		remote_ot: temp_alarm_pkg::OT_LIMIT_RST, // RULE_14
		hyst: temp_alarm_pkg::HYST_RST, // RULE_14
		cfg: temp_alarm_pkg::CONFIG_RST, status: 8'h00,
		status_seen: 8'h00, pending: 1'b0, one_shot_pend: 1'b0,
		conv_start: 1'b0, conv_enable: 1'b1, alert_oe: 1'b0,
		overtemp_oe: 1'b0, rd_data: 8'h00};

	// ============================================================
	// Reset release
	logic [1:0] rst_sync;
	logic arst_n;

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			rst_sync <= 2'b00;
		end else begin
			rst_sync <= {rst_sync[0], 1'b1};
		end
	end
	assign arst_n = rst_sync[1];

	// ============================================================
	// Channel comparators and alert responder
	top_reg_t r;
	top_reg_t next_r;
	logic [7:0] rd_v [2];
	logic [7:0] hi_v [2];
	logic [7:0] lo_v [2];
	logic [7:0] ot_v [2];
	logic [1:0] hi_c;
	logic [1:0] lo_c;
	logic [1:0] ot_f;
	logic [1:0] ot2_f;
	logic ara_done;
	logic [7:0] cond;
	logic mode2;

	assign rd_v[0] = r.local_temp;
	assign rd_v[1] = r.remote_temp;
	assign hi_v[0] = r.local_high;
	assign hi_v[1] = r.remote_high;
	assign lo_v[0] = r.local_low;
	assign lo_v[1] = r.remote_low;
	assign ot_v[0] = r.local_ot;
	assign ot_v[1] = r.remote_ot;

	// Comparisons run every cycle on stored readings, so they keep
	// working in standby and react at once to rewritten limits.
	for (genvar ch = 0; ch < 2; ch++) begin : g_chan // RULE_22
		limit_comparator u_cmp (
			.sys_clk(sys_clk),
			.arst_n(arst_n),
			.ce(ce),
			.reading(rd_v[ch]),
			.high_lim(hi_v[ch]),
			.low_lim(lo_v[ch]),
			.ot_lim(ot_v[ch]),
			.hyst(r.hyst), // RULE_13
			.hi_cond(hi_c[ch]),
			.lo_cond(lo_c[ch]),
			.ot_flag(ot_f[ch]),
			.ot2_flag(ot2_f[ch])
		);
	end

	ara_responder u_ara (
		.sys_clk(sys_clk),
		.arst_n(arst_n),
		.ce(ce),
		.scl_pin(scl_pin),
		.sda_pin(sda_pin),
		.arm(ara_arm),
		.pending(r.alert_oe & ~mode2),
		.sda_oe(sda_oe),
		.done(ara_done),
		.lost()
	);

	// ============================================================
	// Alarm conditions
	assign mode2 = r.cfg[temp_alarm_pkg::CFG_SECOND_OT];

	always_comb begin
		cond = 8'h00;
		cond[temp_alarm_pkg::ST_LOCAL_HIGH] = mode2 ? ot2_f[0] : hi_c[0]; // RULE_16
		cond[temp_alarm_pkg::ST_LOCAL_LOW] = ~mode2 & lo_c[0]; // RULE_02
		cond[temp_alarm_pkg::ST_REMOTE_HIGH] = mode2 ? ot2_f[1] : hi_c[1];
		cond[temp_alarm_pkg::ST_REMOTE_LOW] = ~mode2 & lo_c[1];
		cond[temp_alarm_pkg::ST_OPEN] = r.open_s[1]; // RULE_17
		cond[temp_alarm_pkg::ST_REMOTE_OT] = ot_f[1];
		cond[temp_alarm_pkg::ST_LOCAL_OT] = ot_f[0];
	end

	// ============================================================
	// Next state
	always_comb begin
		logic clr_any;
		logic [7:0] clr_mask;
		logic alert_cond;
		clr_any = 1'b0;
		clr_mask = 8'h00;
		alert_cond = 1'b0;
		next_r = r;
		next_r.open_s = {r.open_s[0], diode_open};
		next_r.conv_start = 1'b0;
		if (wr_stb) begin
			case (wr_addr)
				temp_alarm_pkg::ADDR_CONFIG: next_r.cfg = wr_data;
				temp_alarm_pkg::ADDR_LOCAL_HIGH: next_r.local_high = wr_data; // RULE_01
				temp_alarm_pkg::ADDR_LOCAL_LOW: next_r.local_low = wr_data;
				temp_alarm_pkg::ADDR_REMOTE_HIGH: next_r.remote_high = wr_data;
				temp_alarm_pkg::ADDR_REMOTE_LOW: next_r.remote_low = wr_data;
				temp_alarm_pkg::ADDR_LOCAL_OT: next_r.local_ot = wr_data;
				temp_alarm_pkg::ADDR_REMOTE_OT: next_r.remote_ot = wr_data;
				temp_alarm_pkg::ADDR_HYST:
					next_r.hyst = wr_data & temp_alarm_pkg::HYST_MASK; // RULE_14
				temp_alarm_pkg::ADDR_ONE_SHOT: begin
					if (r.cfg[temp_alarm_pkg::CFG_STANDBY]) begin // RULE_21
						next_r.conv_start = 1'b1;
						next_r.one_shot_pend = 1'b1;
					end
				end
				default: begin
				end
			endcase
		end
		// Results landing in standby belong to an aborted conversion
		// unless a single conversion was asked for.
		if (conv_done && (!r.cfg[temp_alarm_pkg::CFG_STANDBY] ||
				r.one_shot_pend)) begin // RULE_20
			next_r.local_temp = local_reading;
			next_r.remote_temp = remote_reading;
			// A one-shot written in this same cycle must survive.
			next_r.one_shot_pend = next_r.conv_start;
		end
		next_r.conv_enable = ~next_r.cfg[temp_alarm_pkg::CFG_STANDBY]; // RULE_19

		// On a status read only bits the host actually saw are cleared, and only
		// once the byte is out, so nothing raised mid-read is lost.
		clr_any = status_read_done | ara_done;
		clr_mask = status_read_done ? r.status_seen : 8'hff; // RULE_23
		if (rd_stb && rd_addr == temp_alarm_pkg::ADDR_STATUS) begin
			next_r.status_seen = r.status;
		end
		for (int i = temp_alarm_pkg::ST_OPEN;
				i <= temp_alarm_pkg::ST_LOCAL_HIGH; i++) begin
			next_r.status[i] = (r.status[i] & ~(clr_any & clr_mask[i] &
				~cond[i])) | cond[i]; // RULE_04
		end
		if (mode2) begin // RULE_16
			next_r.status[temp_alarm_pkg::ST_LOCAL_HIGH] =
				cond[temp_alarm_pkg::ST_LOCAL_HIGH];
			next_r.status[temp_alarm_pkg::ST_REMOTE_HIGH] =
				cond[temp_alarm_pkg::ST_REMOTE_HIGH];
		end
		next_r.status[temp_alarm_pkg::ST_REMOTE_OT] = ot_f[1]; // RULE_12
		next_r.status[temp_alarm_pkg::ST_LOCAL_OT] = ot_f[0];
		next_r.status[temp_alarm_pkg::ST_BUSY] = next_r.one_shot_pend;

		alert_cond = |cond[temp_alarm_pkg::ST_LOCAL_HIGH:
			temp_alarm_pkg::ST_OPEN];
		next_r.pending = r.pending | alert_cond; // RULE_05
		if (ara_done && !alert_cond) begin // RULE_11
			next_r.pending = 1'b0;
		end
		if (rd_stb && rd_addr == temp_alarm_pkg::ADDR_RELEASE && // RULE_18
				!alert_cond && !(|next_r.status[
				temp_alarm_pkg::ST_LOCAL_HIGH:temp_alarm_pkg::ST_OPEN])) begin
			next_r.pending = 1'b0;
		end
		if (next_r.cfg[temp_alarm_pkg::CFG_SECOND_OT]) begin // RULE_16
			next_r.alert_oe = |ot2_f;
		end else begin
			next_r.alert_oe = next_r.pending &
				~next_r.cfg[temp_alarm_pkg::CFG_ALERT_MASK]; // RULE_06
		end
		next_r.overtemp_oe = |ot_f; // RULE_12

		if (rd_stb) begin
			unique case (rd_addr)
				temp_alarm_pkg::ADDR_LOCAL_TEMP: next_r.rd_data = r.local_temp;
				temp_alarm_pkg::ADDR_REMOTE_TEMP: next_r.rd_data = r.remote_temp;
				temp_alarm_pkg::ADDR_STATUS: next_r.rd_data = r.status; // RULE_03
				temp_alarm_pkg::ADDR_CONFIG: next_r.rd_data = r.cfg;
				temp_alarm_pkg::ADDR_LOCAL_HIGH: next_r.rd_data = r.local_high;
				temp_alarm_pkg::ADDR_LOCAL_LOW: next_r.rd_data = r.local_low;
				temp_alarm_pkg::ADDR_REMOTE_HIGH: next_r.rd_data = r.remote_high;
				temp_alarm_pkg::ADDR_REMOTE_LOW: next_r.rd_data = r.remote_low;
				temp_alarm_pkg::ADDR_LOCAL_OT: next_r.rd_data = r.local_ot;
				temp_alarm_pkg::ADDR_REMOTE_OT: next_r.rd_data = r.remote_ot;
				temp_alarm_pkg::ADDR_HYST: next_r.rd_data = r.hyst;
				default: next_r.rd_data = 8'h00;
			endcase
		end
	end

	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			r <= TOP_RST;
		end else if (ce) begin
			r <= next_r;
		end
	end

	assign rd_data = r.rd_data;
	assign conv_enable = r.conv_enable;
	assign conv_start = r.conv_start;
	assign alert_oe = r.alert_oe;
	assign overtemp_oe = r.overtemp_oe;

	// ============================================================
	// Checks
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!arst_n || !ce);

	sequence s_one_shot_wr;
		wr_stb && wr_addr == temp_alarm_pkg::ADDR_ONE_SHOT &&
			r.cfg[temp_alarm_pkg::CFG_STANDBY];
	endsequence
	sequence s_pulse_once;
		conv_start ##1 !conv_start;
	endsequence

	chk_high_alarm: // RULE_02
	assert property (!mode2 && hi_c[0] |=>
		r.status[temp_alarm_pkg::ST_LOCAL_HIGH] && r.pending)
		else $error("high limit breach not reported");
	chk_sticky_hold: // RULE_04
	assert property (r.status[temp_alarm_pkg::ST_LOCAL_LOW] &&
		!status_read_done && !ara_done |=>
		r.status[temp_alarm_pkg::ST_LOCAL_LOW] || $past(wr_stb))
		else $error("status bit dropped without a read");
	chk_read_clear: // RULE_23
	assert property (status_read_done && !wr_stb && !mode2 &&
		r.status_seen[temp_alarm_pkg::ST_LOCAL_LOW] &&
		!cond[temp_alarm_pkg::ST_LOCAL_LOW] |=>
		!r.status[temp_alarm_pkg::ST_LOCAL_LOW])
		else $error("status bit not cleared after read");
	chk_alert_held: // RULE_05
	assert property (r.pending && !ara_done && !rd_stb |=> r.pending)
		else $error("alert released without a response");
	chk_mask_pin: // RULE_06
	assert property (r.cfg[temp_alarm_pkg::CFG_ALERT_MASK] && !mode2
		|-> !alert_oe)
		else $error("masked alarm pin was driven");
	chk_open_alarm: // RULE_17
	assert property (r.open_s[1] |=>
		r.status[temp_alarm_pkg::ST_OPEN] && r.pending)
		else $error("open diode did not raise alarm");
	chk_ot_pin: // RULE_12
	assert property (##1 overtemp_oe == $past(|ot_f))
		else $error("overtemp pin does not follow flags");
	chk_mode2_pin: // RULE_16
	assert property (##1 mode2 |-> alert_oe == $past(|ot2_f))
		else $error("second over-temperature pin wrong");
	chk_standby_keep: // RULE_20
	assert property (r.cfg[temp_alarm_pkg::CFG_STANDBY] &&
		!r.one_shot_pend && conv_done |=>
		$stable(r.local_temp) && $stable(r.remote_temp))
		else $error("standby result was stored");
	chk_one_shot: // RULE_21
	assert property (s_one_shot_wr |=> s_pulse_once)
		else $error("one-shot write gave no single start");
endmodule // temperature_alarm_logic

// ---- temp_alarm_pkg.sv ----
// Constants shared by the temperature alarm logic and its helpers.
// Assumes the serial framing engine and the converter sit outside.
package temp_alarm_pkg;
	// ============================================================
	// Register addresses
	localparam logic [7:0] ADDR_LOCAL_TEMP = 8'h00;
	localparam logic [7:0] ADDR_REMOTE_TEMP = 8'h01;
	localparam logic [7:0] ADDR_STATUS = 8'h02;
	localparam logic [7:0] ADDR_CONFIG = 8'h03;
	localparam logic [7:0] ADDR_LOCAL_HIGH = 8'h04;
	localparam logic [7:0] ADDR_LOCAL_LOW = 8'h05;
	localparam logic [7:0] ADDR_REMOTE_HIGH = 8'h06;
	localparam logic [7:0] ADDR_REMOTE_LOW = 8'h07;
	localparam logic [7:0] ADDR_LOCAL_OT = 8'h08;
	localparam logic [7:0] ADDR_REMOTE_OT = 8'h09;
	localparam logic [7:0] ADDR_HYST = 8'h0a;
	localparam logic [7:0] ADDR_ONE_SHOT = 8'h0f;
	localparam logic [7:0] ADDR_RELEASE = 8'h42;
	// ============================================================
	// Configuration and status bit positions
	localparam int CFG_ALERT_MASK = 7;
	localparam int CFG_STANDBY = 6;
	localparam int CFG_SECOND_OT = 5;
	localparam int ST_BUSY = 7;
	localparam int ST_LOCAL_HIGH = 6;
	localparam int ST_LOCAL_LOW = 5;
	localparam int ST_REMOTE_HIGH = 4;
	localparam int ST_REMOTE_LOW = 3;
	localparam int ST_OPEN = 2;
	localparam int ST_REMOTE_OT = 1;
	localparam int ST_LOCAL_OT = 0;
	// ============================================================
	// Reset values and hysteresis mask
	localparam logic [7:0] OT_LIMIT_RST = 8'h55;
	localparam logic [7:0] HYST_RST = 8'h0a;
	localparam logic [7:0] HIGH_LIMIT_RST = 8'h46;
	localparam logic [7:0] LOW_LIMIT_RST = 8'h00;
	localparam logic [7:0] CONFIG_RST = 8'h00;
	localparam logic [7:0] HYST_MASK = 8'h7f;
	// ============================================================
	// Alert response
	localparam logic [6:0] DEVICE_ADDR = 7'h4c;
	localparam logic [7:0] ARA_DATA = {DEVICE_ADDR, 1'b1};
	localparam logic [3:0] ARA_LAST_BIT = 4'h7;
	localparam logic [3:0] ARA_BIT_STEP = 4'h1;
endpackage

// ---- limit_comparator.sv ----
// One channel's limit comparisons and over-temperature hysteresis.
// Assumes reading and limits are stable register values on sys_clk.
`timescale 1ns/1ps
module limit_comparator (
	input wire logic sys_clk, // System clock.
	input wire logic arst_n, // Synchronised reset, active low.
	input wire logic ce, // Clock enable.
	input wire logic [7:0] reading, // Latest conversion result.
	input wire logic [7:0] high_lim, // High alarm limit.
	input wire logic [7:0] low_lim, // Low alarm limit.
	input wire logic [7:0] ot_lim, // Over-temperature limit.
	input wire logic [7:0] hyst, // Shared hysteresis.
	output logic hi_cond, // Reading above high limit.
	output logic lo_cond, // Reading at or below low limit.
	output logic ot_flag, // Over-temperature flag.
	output logic ot2_flag // High limit with hysteresis.
);
	typedef struct packed {
		logic ot;
		logic ot2;
	} cmp_reg_t;

	cmp_reg_t r;
	cmp_reg_t next_r;

	// Sets above the limit, clears below limit minus hysteresis.
	// Summing avoids an underflow when hysteresis exceeds the limit.
	function automatic logic hyst_next(input logic flag,
			input logic [7:0] rd, input logic [7:0] lim,
			input logic [7:0] hy);
		logic [8:0] sum;
		sum = {1'b0, rd} + {1'b0, hy};
		if (rd > lim) begin
			hyst_next = 1'b1;
		end else if (sum < {1'b0, lim}) begin
			hyst_next = 1'b0;
		end else begin
			hyst_next = flag;
		end
	endfunction

	always_comb begin
		next_r = r;
		next_r.ot = hyst_next(r.ot, reading, ot_lim, hyst); // RULE_12
		next_r.ot2 = hyst_next(r.ot2, reading, high_lim, hyst); // RULE_16
	end

	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			r <= '0;
		end else if (ce) begin
			r <= next_r;
		end
	end

	assign hi_cond = reading > high_lim; // RULE_02
	assign lo_cond = reading <= low_lim; // RULE_02
	assign ot_flag = r.ot;
	assign ot2_flag = r.ot2;

	default clocking @(posedge sys_clk); endclocking
	default disable iff (!arst_n || !ce);

	chk_ot_set: // RULE_12
	assert property (reading > ot_lim |=> ot_flag)
		else $error("over-temperature flag did not set");
	chk_ot_clear: // RULE_13
	assert property (({1'b0, reading} + {1'b0, hyst} < {1'b0, ot_lim})
		|=> !ot_flag)
		else $error("over-temperature flag did not clear");
endmodule // limit_comparator

// ---- ara_responder.sv ----
// Answers the alert response read on the serial pins.
// Assumes arm pulses before the clock falls after the address byte.
`timescale 1ns/1ps
module ara_responder (
	input wire logic sys_clk, // System clock.
	input wire logic arst_n, // Synchronised reset, active low.
	input wire logic ce, // Clock enable.
	input wire logic scl_pin, // Serial clock pin level.
	input wire logic sda_pin, // Serial data pin level.
	input wire logic arm, // Alert response address was seen.
	input wire logic pending, // Alert is pending.
	output logic sda_oe, // Pull data line low.
	output logic done, // Address byte sent and won.
	output logic lost // Arbitration lost.
);
	typedef enum logic [3:0] {
		R_IDLE = 4'b0001,
		R_WAIT = 4'b0010,
		R_ACK = 4'b0100,
		R_DATA = 4'b1000
	} ara_state_t;

	typedef struct packed {
		logic [1:0] scl_s;
		logic [1:0] sda_s;
		logic scl_q;
		ara_state_t st;
		logic [7:0] sh;
		logic [3:0] cnt;
		logic sda_oe;
		logic done;
		logic lost;
	} ara_reg_t;

	// Synchronisers start at the idle bus level so that no false edge
	// follows reset.
	localparam ara_reg_t ARA_RST = '{scl_s: 2'b11, sda_s: 2'b11,
		scl_q: 1'b1, st: R_IDLE, sh: 8'h00, cnt: 4'h0, sda_oe: 1'b0,
		done: 1'b0, lost: 1'b0};

	ara_reg_t r;
	ara_reg_t next_r;
	logic fall;
	logic rise;

	localparam logic [7:0] ARA_DATA_L = temp_alarm_pkg::ARA_DATA;

	assign fall = r.scl_q & ~r.scl_s[1];
	assign rise = ~r.scl_q & r.scl_s[1];

	always_comb begin
		next_r = r;
		next_r.scl_s = {r.scl_s[0], scl_pin};
		next_r.sda_s = {r.sda_s[0], sda_pin};
		next_r.scl_q = r.scl_s[1];
		next_r.done = 1'b0;
		next_r.lost = 1'b0;
		unique case (r.st)
			R_IDLE: begin
				// Without a pending alert the ack stays high.
				if (arm && pending) begin // RULE_09
					next_r.st = R_WAIT;
				end
			end
			R_WAIT: begin
				if (fall) begin
					next_r.sda_oe = 1'b1; // RULE_08
					next_r.st = R_ACK;
				end
			end
			R_ACK: begin
				if (fall) begin
					next_r.sh = ARA_DATA_L; // RULE_08
					next_r.cnt = 4'h0;
					next_r.sda_oe = ~ARA_DATA_L[7];
					next_r.st = R_DATA;
				end
			end
			R_DATA: begin
				// A released one read back as zero means a lower
				// address is on the wire; back off for a retry.
				if (rise && r.sh[7] && !r.sda_s[1]) begin // RULE_10
					next_r.sda_oe = 1'b0;
					next_r.lost = 1'b1;
					next_r.st = R_IDLE;
				end else if (fall) begin
					if (r.cnt == temp_alarm_pkg::ARA_LAST_BIT) begin
						next_r.sda_oe = 1'b0;
						next_r.done = 1'b1; // RULE_11
						next_r.st = R_IDLE;
					end else begin
						next_r.sh = {r.sh[6:0], 1'b0};
						next_r.cnt = r.cnt + temp_alarm_pkg::ARA_BIT_STEP;
						next_r.sda_oe = ~r.sh[6];
					end
				end
			end
		endcase
	end

	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			r <= ARA_RST;
		end else if (ce) begin
			r <= next_r;
		end
	end

	assign sda_oe = r.sda_oe;
	assign done = r.done;
	assign lost = r.lost;

	default clocking @(posedge sys_clk); endclocking
	default disable iff (!arst_n || !ce);

	sequence s_nack_arm;
		arm && !pending && r.st == R_IDLE;
	endsequence
	sequence s_ack_arm;
		arm && pending && r.st == R_IDLE;
	endsequence
	sequence s_lose;
		r.st == R_DATA && rise && r.sh[7] && !r.sda_s[1];
	endsequence

	chk_ara_nack: // RULE_09
	assert property (s_nack_arm |=> r.st == R_IDLE && !sda_oe)
		else $error("answered alert response without pending alert");
	chk_ara_ack: // RULE_08
	assert property (s_ack_arm |=> r.st == R_WAIT)
		else $error("pending alert did not arm the response");
	chk_ara_lose: // RULE_10
	assert property (s_lose |=> lost && !sda_oe && r.st == R_IDLE)
		else $error("lost arbitration but kept driving");
endmodule // ara_responder

// ---- host_model.sv ----
// SMBus host model that clocks an alert response read on the pins.
// Assumes the framing engine has already flagged the address byte.
`timescale 1ns/1ps
module host_model (
	output logic scl, // Serial clock, high outside frames.
	input wire logic dev_oe, // Device pulls data low.
	input wire logic rival, // Lower-address device pulls data low.
	output wire logic sda // Data line level, pulled up.
);
	// The host only listens during this read; the line is a wired AND.
	assign sda = !dev_oe && !rival;
	initial scl = 1'b1;
	// ============================================================
	// Acknowledge, eight data bits and the host's closing clock.
	task automatic ara_read(output logic ack, output logic [7:0] b);
		for (int i = 0; i < 10; i++) begin
			scl = 1'b0;
			#100;
			scl = 1'b1;
			#50;
			if (i == 0)
				ack = sda;
			else if (i < 9)
				b = {b[6:0], sda};
			#50;
		end
	endtask
endmodule // host_model

// ---- tb_top.sv ----
// Self-checking bench for the temperature alarm logic.
// Assumes the host model serves the pins; strobes come from here.
`timescale 1ns/1ps
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin \
	fails++; $display("[ERR] %s exp %h got %h", n, e, g); end end
module tb_top;
	logic sys_clk, rst_n, wr_stb, rd_stb, rdn, arm, conv, dopen, ack, rival;
	logic [7:0] wr_addr, wr_data, rd_addr, loc, rem, b;
	logic [7:0] rd_data;
	logic sda_oe, conv_enable, conv_start, alert_oe, overtemp_oe, scl, sda;
	int fails = 0;
	int samples_checked = 0;
	host_model host (.scl(scl), .dev_oe(sda_oe), .rival(rival),
		.sda(sda));
	temperature_alarm_logic dut (.sys_clk(sys_clk), .rst_n(rst_n),
		.ce(1'b1), .scl_pin(scl), .sda_pin(sda), .sda_oe(sda_oe),
		.wr_stb(wr_stb), .wr_addr(wr_addr), .wr_data(wr_data),
		.rd_stb(rd_stb), .rd_addr(rd_addr), .rd_data(rd_data),
		.status_read_done(rdn), .ara_arm(arm), .conv_done(conv),
		.local_reading(loc), .remote_reading(rem), .diode_open(dopen),
		.conv_enable(conv_enable), .conv_start(conv_start),
		.alert_oe(alert_oe), .overtemp_oe(overtemp_oe));
	initial begin
		sys_clk = 1'b0;
		forever #12.5 sys_clk = ~sys_clk;
	end
	// ============================================================
	// Bus and strobe tasks.
	task automatic wr(input logic [7:0] a, d);
		@(posedge sys_clk);
		wr_stb <= 1'b1;
		wr_addr <= a;
		wr_data <= d;
		@(posedge sys_clk);
		wr_stb <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a);
		@(posedge sys_clk);
		rd_stb <= 1'b1;
		rd_addr <= a;
		@(posedge sys_clk);
		rd_stb <= 1'b0;
		@(posedge sys_clk);
		#1;
	endtask
	task automatic rdc(input logic [7:0] a, e);
		rd(a);
		`CHK("rd_data", e, rd_data)
	endtask
	task automatic cv(input logic [7:0] l, r);
		@(posedge sys_clk);
		conv <= 1'b1;
		loc <= l;
		rem <= r;
		@(posedge sys_clk);
		conv <= 1'b0;
		repeat (4) @(posedge sys_clk);
		#1;
	endtask
	task automatic done_pulse;
		@(posedge sys_clk);
		rdn <= 1'b1;
		@(posedge sys_clk);
		rdn <= 1'b0;
	endtask
	task automatic arq;
		@(posedge sys_clk);
		arm <= 1'b1;
		@(posedge sys_clk);
		arm <= 1'b0;
		// The pins move off the sampling edge of sys_clk.
		#5;
		host.ara_read(ack, b);
		repeat (4) @(posedge sys_clk);
		#1;
	endtask
	// Readings reset to zero, at the low limits, so rst loads higher readings and services the alarm before every test.
	task automatic rst;
		rst_n <= 1'b0;
		dopen <= 1'b0;
		repeat (10) @(posedge sys_clk);
		rst_n <= 1'b1;
		repeat (4) @(posedge sys_clk);
		cv(8'h20, 8'h10);
		rd(8'h02);
		done_pulse();
		arq();
	endtask
	// ============================================================
	// Scenarios.
	task automatic t_reset;
		rst();
		`CHK("conv_enable", 1'b1, conv_enable)
		rdc(8'h08, 8'h55);
		rdc(8'h09, 8'h55);
		rdc(8'h0a, 8'h0a);
		wr(8'h0a, 8'hff);
		rdc(8'h0a, 8'h7f);
		rdc(8'h02, 8'h00);
		$display("t_reset done");
	endtask
	task automatic t_alarm;
		rst();
		wr(8'h04, 8'h30);
		cv(8'h31, 8'h00);
		`CHK("alert_oe", 1'b1, alert_oe)
		cv(8'h20, 8'h10);
		rdc(8'h02, 8'h48);
		cv(8'h20, 8'h00);
		done_pulse();
		rdc(8'h02, 8'h08);
		cv(8'h20, 8'h10);
		done_pulse();
		rdc(8'h02, 8'h00);
		`CHK("alert_oe", 1'b1, alert_oe)
		rival <= 1'b1;
		arq();
		`CHK("ara_byte", 8'h00, b)
		`CHK("alert_oe", 1'b1, alert_oe)
		rival <= 1'b0;
		arq();
		`CHK("ack", 1'b0, ack)
		`CHK("ara_byte", 8'h99, b)
		`CHK("alert_oe", 1'b0, alert_oe)
		arq();
		`CHK("ack", 1'b1, ack)
		`CHK("ara_byte", 8'hff, b)
		$display("t_alarm done");
	endtask
	task automatic t_mask;
		rst();
		wr(8'h03, 8'h80);
		wr(8'h06, 8'h86);
		cv(8'h50, 8'h50);
		`CHK("alert_oe", 1'b0, alert_oe)
		rdc(8'h02, 8'h40);
		$display("t_mask done");
	endtask
	task automatic t_ot;
		rst();
		wr(8'h0a, 8'h85);
		cv(8'h56, 8'h56);
		`CHK("overtemp_oe", 1'b1, overtemp_oe)
		cv(8'h4f, 8'h50);
		`CHK("overtemp_oe", 1'b1, overtemp_oe)
		cv(8'h4f, 8'h4f);
		`CHK("overtemp_oe", 1'b0, overtemp_oe)
		wr(8'h03, 8'ha0);
		cv(8'h50, 8'h10);
		`CHK("alert_oe", 1'b1, alert_oe)
		cv(8'h41, 8'h10);
		`CHK("alert_oe", 1'b1, alert_oe)
		cv(8'h40, 8'h10);
		`CHK("alert_oe", 1'b0, alert_oe)
		$display("t_ot done");
	endtask
	task automatic t_standby;
		rst();
		wr(8'h03, 8'h40);
		cv(8'h60, 8'h60);
		`CHK("conv_enable", 1'b0, conv_enable)
		wr(8'h04, 8'h1f);
		rdc(8'h00, 8'h20);
		`CHK("alert_oe", 1'b1, alert_oe)
		wr(8'h0f, 8'h5a);
		#1 `CHK("conv_start", 1'b1, conv_start)
		cv(8'h21, 8'h10);
		rdc(8'h00, 8'h21);
		rst();
		dopen <= 1'b1;
		repeat (6) @(posedge sys_clk);
		#1 `CHK("alert_oe", 1'b1, alert_oe)
		rdc(8'h02, 8'h04);
		dopen <= 1'b0;
		repeat (4) @(posedge sys_clk);
		done_pulse();
		rd(8'h42);
		`CHK("alert_oe", 1'b0, alert_oe)
		$display("t_standby done");
	endtask
	task automatic summarize;
		$display("checks %0d fails %0d", samples_checked, fails);
		if (fails == 0 && samples_checked > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	initial begin
		{rst_n, wr_stb, rd_stb, rdn, arm, conv, dopen, rival} = '0;
		{wr_addr, wr_data, rd_addr, loc, rem} = '0;
		t_reset();
		t_alarm();
		t_mask();
		t_ot();
		t_standby();
		summarize();
	end
	initial begin
		#1000000;
		fails++;
		summarize();
	end
endmodule // tb_top
